// >>> ises_consts.vh
/*
 * Constants for the instrument status and event register bank:
 * command codes, bit positions, valid-bit masks, reset values and
 * error-queue codes.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef ISES_CONSTS_VH
`define ISES_CONSTS_VH

// ****************************************
// Command codes on the command port
// ****************************************
`define ISES_CMD_ESR_QUERY 4'h0
`define ISES_CMD_ESE_SET 4'h1
`define ISES_CMD_ESE_QUERY 4'h2
`define ISES_CMD_OPER_COND_QUERY 4'h3
`define ISES_CMD_OPER_EVENT_QUERY 4'h4
`define ISES_CMD_OPER_ENABLE_SET 4'h5
`define ISES_CMD_OPER_ENABLE_QUERY 4'h6
`define ISES_CMD_QUES_COND_QUERY 4'h7
`define ISES_CMD_QUES_EVENT_QUERY 4'h8
`define ISES_CMD_QUES_ENABLE_SET 4'h9
`define ISES_CMD_QUES_ENABLE_QUERY 4'hA
`define ISES_CMD_COV_COND_QUERY 4'hB
`define ISES_CMD_COV_EVENT_QUERY 4'hC
`define ISES_CMD_COV_ENABLE_SET 4'hD
`define ISES_CMD_COV_ENABLE_QUERY 4'hE
`define ISES_CMD_CLEAR_STATUS 4'hF

// ****************************************
// Event status register bits
// ****************************************
`define ISES_ESR_OPC 0
`define ISES_ESR_QUERY_ERR 2
`define ISES_ESR_DEV_ERR 3
`define ISES_ESR_EXEC_ERR 4
`define ISES_ESR_CMD_ERR 5
`define ISES_ESR_USER_REQ 6
`define ISES_ESR_POWER_ON 7
`define ISES_ESR_VALID 8'hFD
`define ISES_ESR_RESET 8'h80
`define ISES_ESE_RESET 8'h00

// ****************************************
// Operation register bits
// ****************************************
`define ISES_OPER_ALIGN 0
`define ISES_OPER_SELFTEST 1
`define ISES_OPER_AUTO_SETUP 2
`define ISES_OPER_AWAIT_TRIG 3
`define ISES_OPER_VALID 16'h000F

// ****************************************
// Questionable register bits
// ****************************************
`define ISES_QUES_OVERLOAD 3
`define ISES_QUES_TEMP 4
`define ISES_QUES_CLIP 5
`define ISES_QUES_CAL_MISSING 8
`define ISES_QUES_LIMIT 9
`define ISES_QUES_MASK 12
`define ISES_QUES_VALID 16'h1338
`define ISES_COV_VALID 16'h000F

// ****************************************
// Status byte bits and common resets
// ****************************************
`define ISES_STB_QUES 3
`define ISES_STB_ESB 5
`define ISES_STB_OPER 7
`define ISES_REG16_RESET 16'h0000
`define ISES_REG8_RESET 8'h00

// ****************************************
// Error queue codes (16-bit two's complement)
// ****************************************
`define ISES_ERRQ_DEVICE 16'hFED4
`define ISES_ERRQ_EXECUTION 16'hFF38
`define ISES_ERRQ_COMMAND 16'hFF9C
`define ISES_ERRQ_NONE 16'h0000

`endif

// >>> ises_status_bank.v
/*
 * Status reporting register bank: event status register with its
 * enable mask, operation and questionable registers (condition, event
 * and enable parts) and the channel overload sub-register, plus the
 * three summary bits they feed into the status byte.
 * Assumes a command parser on the same clock delivers decoded command
 * codes and one-cycle error/event pulses; all inputs share mclk_i.
 */
// Behaviour
// - Event bit rising while enabled sets the event summary in the status byte.
// - Operation-complete bit set after its command once earlier commands finish.
// - Event bit 2 flags a query error from the controller.
// - Event bit 3 on device error, logged with a code from -300 to -399.
// - Event bit 4 on execution error, logged with a code from -200 to -300 unless a device error comes in the same cycle.
// - Event bit 5 on command error, logged with a code from -100 to -200 unless a device or execution error comes in the same cycle.
// - Event bit 6 set on switch from remote to manual control.
// - Event bit 7 set at power on.
// - Operation register offers readable condition and read-cleared event parts.
// - Operation condition bit 0 high throughout a self alignment.
// - Operation condition bit 1 high while selftest runs.
// - Operation condition bit 2 high during automatic setup.
// - Operation condition bit 3 high while waiting for a trigger.
// - Bit 15 of operation and questionable reads zero; unused bits stay clear.
// - Questionable bit 3 set while an overload sub-register event bit that is also enabled is set.
// - Questionable bit 4 set on a questionable temperature.
// - Questionable bit 5 set on converter clipping.
// - Questionable bit 8 set when calibration data is missing.
// - Questionable bit 9 set on a measurement limit violation.
// - Questionable bit 12 set on a mask test violation.
// - Overload sub-register bits 0 to 3 flag channels one to four.
// - Status byte bit 5 is the OR of enabled event status bits.
// - Event register and mask are 8 bits; operation and questionable 16 bits.
// - Status byte bit 3 from enabled questionable event bits.
// - Status byte bit 7 from enabled operation event bits.
`timescale 1ns/1ns
`default_nettype none
`include "ises_consts.vh"

module ises_status_bank (
  // Clock, reset, enable
  input wire mclk_i,
  input wire rst_n_i,
  input wire ce_i,
  // Command port
  input wire cmd_valid_i,
  input wire [3:0] cmd_code_i,
  input wire [15:0] cmd_wdata_i,
  output reg rsp_valid_o,
  output reg [15:0] rsp_data_o,
  // Command parser events
  input wire operation_complete_cmd_i,
  input wire cmds_busy_i,
  input wire query_error_i,
  input wire device_error_i,
  input wire execution_error_i,
  input wire command_error_i,
  input wire manual_switch_i,
  // Instrument conditions
  input wire align_active_i,
  input wire selftest_active_i,
  input wire auto_setup_active_i,
  input wire awaiting_trigger_i,
  input wire [3:0] chan_overload_i,
  input wire temperature_questionable_i,
  input wire converter_clip_summary_i,
  input wire calibration_missing_i,
  input wire limit_violation_i,
  input wire mask_violation_i,
  // Error queue entry
  output reg err_log_valid_o,
  output reg [15:0] err_log_code_o,
  // Status byte summaries
  output wire [7:0] status_byte_o
);

  // ****************************************
  // Helpers
  // ****************************************
  // Sticky event update: a set in the clearing cycle wins
  function [15:0] ev_next;
    input [15:0] ev;
    input [15:0] rise;
    input clr;
    begin
      ev_next = (clr ? `ISES_REG16_RESET : ev) | rise;
    end
  endfunction

  // Summary bit: any event bit that is also enabled
  function any_enabled;
    input [15:0] ev;
    input [15:0] en;
    begin
      any_enabled = |(ev & en);
    end
  endfunction

  function is_cmd;
    input [3:0] code;
    begin
      is_cmd = ce_i && cmd_valid_i && (cmd_code_i == code);
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg [7:0] esr_ff;
  reg [7:0] ese_ff;
  reg opc_pending_ff;
  reg [15:0] oper_cond_ff;
  reg [15:0] oper_event_ff;
  reg [15:0] oper_enable_ff;
  reg [15:0] ques_cond_ff;
  reg [15:0] ques_event_ff;
  reg [15:0] ques_enable_ff;
  reg [15:0] cov_cond_ff;
  reg [15:0] cov_event_ff;
  reg [15:0] cov_enable_ff;

  wire clr_all;
  wire [15:0] cov_cond_now;
  wire [15:0] oper_cond_now;
  wire [15:0] ques_cond_now;
  wire cov_summary;
  wire [7:0] esr_set;
  wire opc_fire;
  wire esr_clr;
  wire oper_ev_clr;
  wire ques_ev_clr;
  wire cov_ev_clr;
  wire [15:0] esr_upd;
  wire [15:0] oper_rise;
  wire [15:0] ques_rise;
  wire [15:0] cov_rise;
  wire oper_summary;
  wire esb_summary;
  wire ques_summary;

  assign clr_all = is_cmd(`ISES_CMD_CLEAR_STATUS);
  // Each event part empties on its own query or on clear-status
  assign esr_clr = is_cmd(`ISES_CMD_ESR_QUERY) || clr_all;
  assign oper_ev_clr = is_cmd(`ISES_CMD_OPER_EVENT_QUERY) || clr_all;
  assign ques_ev_clr = is_cmd(`ISES_CMD_QUES_EVENT_QUERY) || clr_all;
  assign cov_ev_clr = is_cmd(`ISES_CMD_COV_EVENT_QUERY) || clr_all;

  // ****************************************
  // Condition parts
  // ****************************************
  assign cov_cond_now = {12'h000, chan_overload_i} & `ISES_COV_VALID;
  assign cov_summary = any_enabled(cov_event_ff, cov_enable_ff);

  assign oper_cond_now = {12'h000,
                          awaiting_trigger_i,
                          auto_setup_active_i,
                          selftest_active_i,
                          align_active_i}
                         & `ISES_OPER_VALID;

  assign ques_cond_now = {3'h0,
                          mask_violation_i,
                          2'h0,
                          limit_violation_i,
                          calibration_missing_i,
                          2'h0,
                          converter_clip_summary_i,
                          temperature_questionable_i,
                          cov_summary,
                          3'h0}
                         & `ISES_QUES_VALID;

  // ****************************************
  // Positive transitions
  // ****************************************
  // A condition bit going from 0 to 1 marks an event; falls mark none
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_rise
      assign oper_rise[gi] = oper_cond_now[gi] & ~oper_cond_ff[gi];
      assign ques_rise[gi] = ques_cond_now[gi] & ~ques_cond_ff[gi];
      assign cov_rise[gi] = cov_cond_now[gi] & ~cov_cond_ff[gi];
    end
  endgenerate

  // ****************************************
  // Event status sources
  // ****************************************
  assign opc_fire = opc_pending_ff && !cmds_busy_i;

  assign esr_set = {1'b0,              // Power-on set by reset value
                    manual_switch_i,
                    command_error_i,
                    execution_error_i,
                    device_error_i,
                    query_error_i,
                    1'b0,
                    opc_fire}
                   & `ISES_ESR_VALID;

  // Read or clear-status empties the register, events in that cycle stay
  assign esr_upd = ev_next({8'h00, esr_ff}, {8'h00, esr_set}, esr_clr);

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      esr_ff <= `ISES_ESR_RESET;
      ese_ff <= `ISES_ESE_RESET;
      opc_pending_ff <= 1'b0;
    end else if (ce_i) begin
      esr_ff <= esr_upd[7:0];
      if (is_cmd(`ISES_CMD_ESE_SET)) begin
        ese_ff <= cmd_wdata_i[7:0];
      end
      if (opc_fire) begin
        opc_pending_ff <= 1'b0;
      end else if (operation_complete_cmd_i) begin
        opc_pending_ff <= 1'b1;
      end
    end
  end

  // Condition parts and positive-transition event parts
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      oper_cond_ff <= `ISES_REG16_RESET;
      oper_event_ff <= `ISES_REG16_RESET;
      ques_cond_ff <= `ISES_REG16_RESET;
      ques_event_ff <= `ISES_REG16_RESET;
      cov_cond_ff <= `ISES_REG16_RESET;
      cov_event_ff <= `ISES_REG16_RESET;
    end else if (ce_i) begin
      oper_cond_ff <= oper_cond_now;
      ques_cond_ff <= ques_cond_now;
      cov_cond_ff <= cov_cond_now;
      oper_event_ff <= ev_next(oper_event_ff, oper_rise, oper_ev_clr);
      ques_event_ff <= ev_next(ques_event_ff, ques_rise, ques_ev_clr);
      cov_event_ff <= ev_next(cov_event_ff, cov_rise, cov_ev_clr);
    end
  end

  // Enable parts, unused bits held at zero
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      oper_enable_ff <= `ISES_REG16_RESET;
      ques_enable_ff <= `ISES_REG16_RESET;
      cov_enable_ff <= `ISES_REG16_RESET;
    end else if (ce_i) begin
      if (is_cmd(`ISES_CMD_OPER_ENABLE_SET)) begin
        oper_enable_ff <= cmd_wdata_i & `ISES_OPER_VALID;
      end
      if (is_cmd(`ISES_CMD_QUES_ENABLE_SET)) begin
        ques_enable_ff <= cmd_wdata_i & `ISES_QUES_VALID;
      end
      if (is_cmd(`ISES_CMD_COV_ENABLE_SET)) begin
        cov_enable_ff <= cmd_wdata_i & `ISES_COV_VALID;
      end
    end
  end

  // ****************************************
  // Query answers
  // ****************************************
  reg [15:0] nxt_rsp_data;
  reg nxt_rsp_valid;

  always @* begin
    nxt_rsp_valid = cmd_valid_i;
    case (cmd_code_i)
      `ISES_CMD_ESR_QUERY: nxt_rsp_data = {8'h00, esr_ff};
      `ISES_CMD_ESE_QUERY: nxt_rsp_data = {8'h00, ese_ff};
      `ISES_CMD_OPER_COND_QUERY: nxt_rsp_data = oper_cond_ff;
      `ISES_CMD_OPER_EVENT_QUERY: nxt_rsp_data = oper_event_ff;
      `ISES_CMD_OPER_ENABLE_QUERY: nxt_rsp_data = oper_enable_ff;
      `ISES_CMD_QUES_COND_QUERY: nxt_rsp_data = ques_cond_ff;
      `ISES_CMD_QUES_EVENT_QUERY: nxt_rsp_data = ques_event_ff;
      `ISES_CMD_QUES_ENABLE_QUERY: nxt_rsp_data = ques_enable_ff;
      `ISES_CMD_COV_COND_QUERY: nxt_rsp_data = cov_cond_ff;
      `ISES_CMD_COV_EVENT_QUERY: nxt_rsp_data = cov_event_ff;
      `ISES_CMD_COV_ENABLE_QUERY: nxt_rsp_data = cov_enable_ff;
      default: begin
        // Settings and clear-status answer nothing
        nxt_rsp_data = `ISES_REG16_RESET;
        nxt_rsp_valid = 1'b0;
      end
    endcase
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= `ISES_REG16_RESET;
    end else if (ce_i) begin
      rsp_valid_o <= nxt_rsp_valid;
      if (nxt_rsp_valid) begin
        rsp_data_o <= nxt_rsp_data;
      end
    end
  end

  // ****************************************
  // Error queue entries
  // ****************************************
  reg [15:0] nxt_err_code;

  always @* begin
    if (device_error_i) begin
      nxt_err_code = `ISES_ERRQ_DEVICE;
    end else if (execution_error_i) begin
      nxt_err_code = `ISES_ERRQ_EXECUTION;
    end else if (command_error_i) begin
      nxt_err_code = `ISES_ERRQ_COMMAND;
    end else begin
      nxt_err_code = `ISES_ERRQ_NONE;
    end
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      err_log_valid_o <= 1'b0;
      err_log_code_o <= `ISES_ERRQ_NONE;
    end else if (ce_i) begin
      err_log_valid_o <= device_error_i || execution_error_i || command_error_i;
      err_log_code_o <= nxt_err_code;
    end
  end

  // ****************************************
  // Status byte summaries
  // ****************************************
  assign oper_summary = any_enabled(oper_event_ff, oper_enable_ff);
  assign esb_summary = any_enabled({8'h00, esr_ff}, {8'h00, ese_ff});
  assign ques_summary = any_enabled(ques_event_ff, ques_enable_ff);
  assign status_byte_o[`ISES_STB_OPER] = oper_summary;
  assign status_byte_o[6] = 1'b0;
  assign status_byte_o[`ISES_STB_ESB] = esb_summary;
  assign status_byte_o[4] = 1'b0;
  assign status_byte_o[`ISES_STB_QUES] = ques_summary;
  assign status_byte_o[2:0] = 3'h0;

endmodule

`default_nettype wire

// >>> ises_host_model.sv
/* Remote controller model issuing commands to the status bank.
   Assumes commands are driven on the falling edge of mclk_i. */
`timescale 1ns/1ns
`default_nettype none
module ises_host_model (
  // Clock
  input wire logic mclk_i,
  // Command port
  output logic cmd_valid_o,
  output logic [3:0] cmd_code_o,
  output logic [15:0] cmd_wdata_o,
  input wire logic rsp_valid_i,
  input wire logic [15:0] rsp_data_i
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = 4'h0;
    cmd_wdata_o = 16'h0000;
  end
  // One command a call; answer taken at the falling edge after the taking edge
  task automatic send(input logic [3:0] code, input logic [15:0] wdata,
      output logic ok, output logic [15:0] rdata);
    @(negedge mclk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o = code;
    cmd_wdata_o = wdata;
    @(negedge mclk_i);
    cmd_valid_o = 1'b0;
    cmd_code_o = ~code;
    cmd_wdata_o = ~wdata;
    ok = rsp_valid_i;
    rdata = rsp_data_i;
  endtask
endmodule
`default_nettype wire

// >>> ises_status_checker.sv
/* Port assertions for the status bank, bound to ises_status_bank.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
`include "ises_consts.vh"
module ises_status_checker (
  // Clock, reset, command port
  input wire logic mclk_i, rst_n_i, ce_i, cmd_valid_i,
  input wire logic [3:0] cmd_code_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic rsp_valid_o,
  input wire logic [15:0] rsp_data_o,
  // Events and results
  input wire logic operation_complete_cmd_i, cmds_busy_i, query_error_i,
  input wire logic device_error_i, execution_error_i, command_error_i, err_log_valid_o,
  input wire logic [15:0] err_log_code_o,
  input wire logic [7:0] status_byte_o
);
  // ****
  // Shadow of the event enable mask
  // ****
  logic [7:0] ese_ff;
  logic is_query;
  assign is_query = cmd_valid_i && !(cmd_code_i inside {4'h1, 4'h5, 4'h9, 4'hD, 4'hF});
  always @(posedge mclk_i) begin
    if (!rst_n_i)
      ese_ff <= `ISES_ESE_RESET;
    else if (ce_i && cmd_valid_i && cmd_code_i == `ISES_CMD_ESE_SET)
      ese_ff <= cmd_wdata_i[7:0];
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_opc_taken;
    ce_i && operation_complete_cmd_i && !cmd_valid_i && ese_ff[0];
  endsequence
  sequence s_idle_done;
    ce_i && !cmds_busy_i && !cmd_valid_i;
  endsequence
  AST_QUERY_ANSWER: assert property (
    ce_i |=> rsp_valid_o == $past(is_query)) else $error("query answer pulse wrong");
  AST_POWER_ON: assert property (
    !$past(rst_n_i) && ce_i && is_query && cmd_code_i == `ISES_CMD_ESR_QUERY
    |=> rsp_data_o == {8'h00, `ISES_ESR_RESET}) else $error("power-on bit missing");
  AST_ESB_QUERY_ERR: assert property (
    ce_i && query_error_i && ese_ff[2] && !cmd_valid_i |=> status_byte_o[`ISES_STB_ESB])
    else $error("event summary not set");
  AST_OPC_DONE: assert property (
    s_opc_taken ##1 s_idle_done |=> status_byte_o[`ISES_STB_ESB])
    else $error("operation complete not flagged");
  AST_DEV_LOG: assert property (
    ce_i && device_error_i |=> err_log_valid_o && err_log_code_o == `ISES_ERRQ_DEVICE)
    else $error("device error code wrong");
  AST_EXEC_LOG: assert property (
    ce_i && execution_error_i && !device_error_i
    |=> err_log_valid_o && err_log_code_o == `ISES_ERRQ_EXECUTION)
    else $error("execution error code wrong");
  AST_CMD_LOG: assert property (
    ce_i && command_error_i && !device_error_i && !execution_error_i
    |=> err_log_valid_o && err_log_code_o == `ISES_ERRQ_COMMAND)
    else $error("command error code wrong");
  AST_LOG_QUIET: assert property (
    ce_i && !device_error_i && !execution_error_i && !command_error_i |=> !err_log_valid_o)
    else $error("error entry without error");
  AST_STB_UNUSED: assert property (
    (status_byte_o & 8'h57) == 8'h00) else $error("unused status byte bit set");
endmodule
bind ises_status_bank ises_status_checker ises_status_checker_inst (.mclk_i(mclk_i),
  .rst_n_i(rst_n_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
  .cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
  .operation_complete_cmd_i(operation_complete_cmd_i), .cmds_busy_i(cmds_busy_i),
  .query_error_i(query_error_i), .device_error_i(device_error_i),
  .execution_error_i(execution_error_i), .command_error_i(command_error_i),
  .err_log_valid_o(err_log_valid_o), .err_log_code_o(err_log_code_o),
  .status_byte_o(status_byte_o));
`default_nettype wire

// >>> tb_instrument_status_event_registers.sv
/* Testbench for the status bank: the host model sends commands, the
   bench drives events and conditions on the falling edge and checks. */
`timescale 1ns/1ns
`default_nettype none
`include "ises_consts.vh"
module tb_instrument_status_event_registers;
  logic clk = 1'b0, rst_n = 1'b0, operation_complete_cmd = 1'b0, busy = 1'b0, ok;
  logic [4:0] ev = 5'h00;
  logic [3:0] oper = 4'h0, ovl = 4'h0;
  logic [4:0] ques = 5'h00;
  logic cmd_valid, rsp_valid, err_valid;
  logic [3:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_data, err_code, rd;
  logic [7:0] stb;
  logic [15:0] errq_exp [0:4] = '{`ISES_ERRQ_NONE, `ISES_ERRQ_DEVICE, `ISES_ERRQ_EXECUTION,
    `ISES_ERRQ_COMMAND, `ISES_ERRQ_NONE};
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  always #50 clk = ~clk;
  ises_status_bank ises_status_bank_inst (.mclk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
    .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_wdata_i(cmd_wdata),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .operation_complete_cmd_i(operation_complete_cmd),
    .cmds_busy_i(busy), .query_error_i(ev[0]), .device_error_i(ev[1]),
    .execution_error_i(ev[2]), .command_error_i(ev[3]), .manual_switch_i(ev[4]),
    .align_active_i(oper[0]), .selftest_active_i(oper[1]),
    .auto_setup_active_i(oper[2]), .awaiting_trigger_i(oper[3]), .chan_overload_i(ovl),
    .temperature_questionable_i(ques[0]), .converter_clip_summary_i(ques[1]),
    .calibration_missing_i(ques[2]), .limit_violation_i(ques[3]),
    .mask_violation_i(ques[4]), .err_log_valid_o(err_valid), .err_log_code_o(err_code),
    .status_byte_o(stb));
  ises_host_model ises_host_model_inst (.mclk_i(clk), .cmd_valid_o(cmd_valid),
    .cmd_code_o(cmd_code), .cmd_wdata_o(cmd_wdata), .rsp_valid_i(rsp_valid),
    .rsp_data_i(rsp_data));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic q(input logic [3:0] code, input logic [15:0] exp);
    ises_host_model_inst.send(code, 16'h0000, ok, rd);
    chk("rsp_valid_o", 16'h0001, {15'h0000, ok});
    chk("rsp_data_o", exp, rd);
  endtask
  task automatic w(input logic [3:0] code, input logic [15:0] d);
    ises_host_model_inst.send(code, d, ok, rd);
  endtask
  task automatic sb(input logic [7:0] exp);
    chk("status_byte_o", {8'h00, exp}, {8'h00, stb});
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ****
  // Test sequence
  // ****
  initial begin
    repeat (3) @(negedge clk);
    fork
      begin @(negedge clk); rst_n = 1'b1; end
    join_none
    q(`ISES_CMD_ESR_QUERY, 16'h0080);
    q(`ISES_CMD_ESR_QUERY, 16'h0000);
    w(`ISES_CMD_ESE_SET, 16'hFFFD);
    q(`ISES_CMD_ESE_QUERY, 16'h00FD);
    for (int i = 0; i < 5; i++) begin
      ev = 5'h01 << i;
      @(negedge clk);
      ev = 5'h00;
      chk("err_log_code_o", errq_exp[i], err_code);
      chk("err_log_valid_o", {15'h0000, errq_exp[i] != `ISES_ERRQ_NONE}, {15'h0000, err_valid});
      sb(8'h20);
      q(`ISES_CMD_ESR_QUERY, 16'h0004 << i);
      sb(8'h00);
    end
    for (int b = 0; b < 2; b++) begin
      busy = b[0];
      operation_complete_cmd = 1'b1;
      @(negedge clk);
      operation_complete_cmd = 1'b0;
      repeat (3) @(negedge clk);
      sb(b ? 8'h00 : 8'h20);
      busy = 1'b0;
      repeat (2) @(negedge clk);
      q(`ISES_CMD_ESR_QUERY, 16'h0001);
    end
    w(`ISES_CMD_OPER_ENABLE_SET, 16'hFFFF);
    q(`ISES_CMD_OPER_ENABLE_QUERY, 16'h000F);
    for (int i = 0; i < 4; i++) begin
      oper = 4'h1 << i;
      repeat (3) @(negedge clk);
      q(`ISES_CMD_OPER_COND_QUERY, 16'h0001 << i);
      sb(8'h80);
      q(`ISES_CMD_OPER_EVENT_QUERY, 16'h0001 << i);
    end
    oper = 4'h0;
    w(`ISES_CMD_QUES_ENABLE_SET, 16'hFFFF);
    q(`ISES_CMD_QUES_ENABLE_QUERY, 16'h1338);
    ques = 5'h1F;
    repeat (3) @(negedge clk);
    q(`ISES_CMD_QUES_COND_QUERY, 16'h1330);
    sb(8'h08);
    q(`ISES_CMD_QUES_EVENT_QUERY, 16'h1330);
    ques = 5'h00;
    w(`ISES_CMD_COV_ENABLE_SET, 16'h0004);
    q(`ISES_CMD_COV_ENABLE_QUERY, 16'h0004);
    ovl = 4'hB;
    repeat (5) @(negedge clk);
    q(`ISES_CMD_COV_COND_QUERY, 16'h000B);
    sb(8'h00);
    ovl = 4'h4;
    repeat (5) @(negedge clk);
    sb(8'h08);
    q(`ISES_CMD_COV_EVENT_QUERY, 16'h000F);
    w(`ISES_CMD_CLEAR_STATUS, 16'h0000);
    q(`ISES_CMD_QUES_EVENT_QUERY, 16'h0000);
    sb(8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
